// file: verilog/pidc_defines.vh
// Constants for the power, identification and first configuration register bank
// Contract
// - Power field: 0x is down, 10 active
// - Part identifier read at offset 0x04
// - Revision identifier read at offset 0x06
// - Maker identifier read at offset 0x0C
// - Bit 12 picks autonomous or direct conversion
// - Bits 10-8 filter code, K 1..16
// - Current update interval follows filter code
// - Filter feedback coefficient equals K minus one
// - Bits 6-4 remote temperature averaging, reset 000
// - Remote temperature update time per averaging code
// - Bit 0 enables closed loop, reset 0
// - Frame: R/W, 7-bit address, 16 data
// - Writes without exactly 24 edges are discarded
`ifndef PIDC_DEFINES_VH
`define PIDC_DEFINES_VH

// -------------------------------------------------------------------------
// Register addresses
// -------------------------------------------------------------------------
`define PIDC_ADDR_POWER      7'h02
`define PIDC_ADDR_PART_ID    7'h04
`define PIDC_ADDR_REV_ID     7'h06
`define PIDC_ADDR_MAKER_ID   7'h0C
`define PIDC_ADDR_CONFIG0    7'h10

// -------------------------------------------------------------------------
// Reset values and field positions
// -------------------------------------------------------------------------
`define PIDC_POWER_RESET     16'h0000
`define PIDC_CONFIG0_RESET   16'h0300
`define PIDC_POWER_ACTIVE    2'h2
`define PIDC_POWER_FACTORY   2'h3
`define PIDC_BIT_TRIGGER     12
`define PIDC_FILT_HI         10
`define PIDC_FILT_LO         8
`define PIDC_AVG_HI          6
`define PIDC_AVG_LO          4
`define PIDC_BIT_LOOP        0
`define PIDC_FILT_MAX        3'h4
`define PIDC_AVG_MAX         3'h5
`define PIDC_FILT_RESET      3'h3
`define PIDC_AVG_RESET       3'h0

// -------------------------------------------------------------------------
// Frame layout
// -------------------------------------------------------------------------
`define PIDC_FRAME_BITS      5'h18
`define PIDC_HDR_BITS        5'h08
`define PIDC_CNT_FULL        5'h18

// -------------------------------------------------------------------------
// Update times in microseconds
// -------------------------------------------------------------------------
`define PIDC_CLK_MHZ         20
`define PIDC_CS_T0_US        200
`define PIDC_CS_T1_US        3400
`define PIDC_CS_T2_US        6600
`define PIDC_CS_T3_US        13000
`define PIDC_CS_T4_US        25600
`define PIDC_RT_T0_US        16000
`define PIDC_RT_T1_US        16000
`define PIDC_RT_T2_US        18000
`define PIDC_RT_T3_US        26000
`define PIDC_RT_T4_US        50000
`define PIDC_RT_T5_US        98000

`endif

// file: verilog/pidc_serial.v
// Serial frame receiver and read shifter for the register bank
`timescale 1ns/100ps
`include "pidc_defines.vh"

module pidc_serial (
    clk,
    rst_n,
    cs_n_s,
    sclk_s,
    sdi_s,
    rd_data,
    wr_stb,
    addr,
    wr_data,
    sdo,
    sdo_oe
);
    input  wire        clk;       // System clock
    input  wire        rst_n;     // Synchronised reset
    input  wire        cs_n_s;    // Synchronised chip select
    input  wire        sclk_s;    // Synchronised serial clock
    input  wire        sdi_s;     // Synchronised serial data in
    input  wire [15:0] rd_data;   // Read data for current address
    output reg         wr_stb;    // One-cycle commit of a write
    output reg  [6:0]  addr;      // Frame address
    output reg  [15:0] wr_data;   // Frame write data
    output reg         sdo;       // Serial data out
    output wire        sdo_oe;    // Output drive enable

    reg  [23:0] shift_r;          // Incoming bits
    reg  [4:0]  cnt_r;            // Rising edges in frame
    reg         sclk_d_r;         // Previous serial clock
    reg         cs_d_r;           // Previous chip select
    reg  [15:0] out_r;            // Read shifter
    reg         read_r;           // Frame is a read
    wire        rise;             // Serial clock rising
    wire        fall;             // Serial clock falling
    wire        frame_end;        // Chip select just rose

    assign rise      = sclk_s & ~sclk_d_r & ~cs_n_s;
    assign fall      = ~sclk_s & sclk_d_r & ~cs_n_s;
    assign frame_end = cs_n_s & ~cs_d_r;
    assign sdo_oe    = ~cs_n_s & read_r;

    // ---------------------------------------------------------------------
    // Frame capture, MSB first, R/W then address then data
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r  <= 24'h000000;
            cnt_r    <= 5'h00;
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
            out_r    <= 16'h0000;
            read_r   <= 1'b0;
            wr_stb   <= 1'b0;
            addr     <= 7'h00;
            wr_data  <= 16'h0000;
            sdo      <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r   <= cs_n_s;
            wr_stb   <= 1'b0;
            if (cs_n_s) begin
                // Idle: restart count for next frame
                cnt_r <= 5'h00;
                if (frame_end && !shift_r[23] && cnt_r == `PIDC_CNT_FULL) begin
                    wr_stb  <= 1'b1;
                    addr    <= shift_r[22:16];
                    wr_data <= shift_r[15:0];
                end
                read_r <= 1'b0;
            end else if (rise) begin
                shift_r <= {shift_r[22:0], sdi_s};
                if (cnt_r != 5'h1F)
                    cnt_r <= cnt_r + 5'h01;          // Saturates at 31
                if (cnt_r == 5'h00)
                    read_r <= sdi_s;
                if (cnt_r == `PIDC_HDR_BITS - 5'h01) begin
                    addr  <= {shift_r[5:0], sdi_s};
                end
            end else if (fall) begin
                // Drive data out on falling edges after the header
                if (cnt_r == `PIDC_HDR_BITS) begin
                    sdo   <= rd_data[15];
                    out_r <= {rd_data[14:0], 1'b0};
                end else if (cnt_r > `PIDC_HDR_BITS) begin
                    sdo   <= out_r[15];
                    out_r <= {out_r[14:0], 1'b0};
                end
            end
        end
    end
endmodule

// file: verilog/pidc_top.v
// Power mode, identification and first configuration register bank
`timescale 1ns/100ps
`include "pidc_defines.vh"

module pidc_top #(
    parameter [15:0] PART_ID    = 16'hA5A5,  // Arbitrary value
    parameter [15:0] REV_ID     = 16'h0003,  // Arbitrary value
    parameter [15:0] MAKER_ID   = 16'h5A5A,  // Arbitrary value
    parameter        TIME_SCALE = 1          // Divides update times for simulation
) (
    SYS_CLK,
    RESET_N,
    CS_N,
    SCLK,
    SDI,
    SDO,
    SDO_OE,
    POWER_ACTIVE,
    CONVERSION_TRIGGER_SELECT,
    FILTER_CODE,
    FILTER_K,
    FILTER_FEEDBACK,
    REMOTE_TEMP_AVERAGING,
    LOOP_ENABLE,
    CS_UPDATE,
    RT_UPDATE
);
    input  wire        SYS_CLK;                    // 20 MHz clock
    input  wire        RESET_N;                    // Asynchronous reset
    input  wire        CS_N;                       // Chip select pin
    input  wire        SCLK;                       // Serial clock pin
    input  wire        SDI;                        // Serial data in pin
    output wire        SDO;                        // Serial data out
    output wire        SDO_OE;                     // SDO drive enable
    output reg         POWER_ACTIVE;               // Analog functions on
    output reg         CONVERSION_TRIGGER_SELECT;  // 1 is direct mode
    output reg  [2:0]  FILTER_CODE;                // Valid filter code
    output reg  [4:0]  FILTER_K;                   // K value
    output reg  [4:0]  FILTER_FEEDBACK;            // K minus one
    output reg  [2:0]  REMOTE_TEMP_AVERAGING;      // Valid averaging code
    output reg         LOOP_ENABLE;                // Closed loop on
    output reg         CS_UPDATE;                  // Current result tick
    output reg         RT_UPDATE;                  // Remote temp result tick

    // ---------------------------------------------------------------------
    // Cycle counts derived from update times
    // ---------------------------------------------------------------------
    localparam integer CS_C0 = `PIDC_CS_T0_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer CS_C1 = `PIDC_CS_T1_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer CS_C2 = `PIDC_CS_T2_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer CS_C3 = `PIDC_CS_T3_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer CS_C4 = `PIDC_CS_T4_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C0 = `PIDC_RT_T0_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C1 = `PIDC_RT_T1_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C2 = `PIDC_RT_T2_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C3 = `PIDC_RT_T3_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C4 = `PIDC_RT_T4_US * `PIDC_CLK_MHZ / TIME_SCALE;
    localparam integer RT_C5 = `PIDC_RT_T5_US * `PIDC_CLK_MHZ / TIME_SCALE;

    reg  [1:0]  rst_sync_r;       // Reset release pipeline
    wire        rst_n;            // Synchronised reset
    reg  [2:0]  sync1_r;          // First stage of pin sync
    reg  [2:0]  sync2_r;          // Second stage of pin sync
    reg  [15:0] power_state_r;          // Power state register
    reg  [15:0] general_config_zero_r;  // First configuration register
    reg  [15:0] rd_data;          // Read mux
    reg  [21:0] cs_cnt_r;         // Current update timer
    reg  [21:0] rt_cnt_r;         // Remote temp update timer
    reg  [21:0] cs_lim;           // Current interval for code
    reg  [21:0] rt_lim;           // Remote interval for code
    wire        wr_stb;
    wire [6:0]  addr;
    wire [15:0] wr_data;
    wire [2:0]  new_filt;
    wire [2:0]  new_avg;

    // Clamp to at least one cycle, shared by both timers
    function [21:0] sat22;
        input integer v;
        begin
            sat22 = (v < 1) ? 22'h000001 : v[21:0];
        end
    endfunction

    // ---------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 3'h1;
            sync2_r <= 3'h1;
        end else begin
            sync1_r <= {SDI, SCLK, CS_N};
            sync2_r <= sync1_r;
        end
    end

    pidc_serial u_serial (
        .clk     (SYS_CLK),
        .rst_n   (rst_n),
        .cs_n_s  (sync2_r[0]),
        .sclk_s  (sync2_r[1]),
        .sdi_s   (sync2_r[2]),
        .rd_data (rd_data),
        .wr_stb  (wr_stb),
        .addr    (addr),
        .wr_data (wr_data),
        .sdo     (SDO),
        .sdo_oe  (SDO_OE)
    );

    // ---------------------------------------------------------------------
    // Read mux; identifiers are constants, unmapped reads zero
    // ---------------------------------------------------------------------
    always @* begin
        case (addr)
            `PIDC_ADDR_POWER:    rd_data = power_state_r;
            `PIDC_ADDR_PART_ID:  rd_data = PART_ID;
            `PIDC_ADDR_REV_ID:   rd_data = REV_ID;
            `PIDC_ADDR_MAKER_ID: rd_data = MAKER_ID;
            `PIDC_ADDR_CONFIG0:  rd_data = general_config_zero_r;
            default:             rd_data = 16'h0000;
        endcase
    end

    // ---------------------------------------------------------------------
    // Register writes; identifier addresses have no storage
    // ---------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            power_state_r         <= `PIDC_POWER_RESET;
            general_config_zero_r <= `PIDC_CONFIG0_RESET;
        end else if (wr_stb) begin
            if (addr == `PIDC_ADDR_POWER)
                power_state_r <= wr_data;
            if (addr == `PIDC_ADDR_CONFIG0)
                general_config_zero_r <= wr_data;
        end
    end

    assign new_filt = general_config_zero_r[`PIDC_FILT_HI:`PIDC_FILT_LO];
    assign new_avg  = general_config_zero_r[`PIDC_AVG_HI:`PIDC_AVG_LO];

    // ---------------------------------------------------------------------
    // Decoded controls; invalid codes keep the last valid setting
    // ---------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            POWER_ACTIVE              <= 1'b0;
            CONVERSION_TRIGGER_SELECT <= 1'b0;
            FILTER_CODE               <= `PIDC_FILT_RESET;
            FILTER_K                  <= 5'h01 << `PIDC_FILT_RESET;
            FILTER_FEEDBACK           <= (5'h01 << `PIDC_FILT_RESET) - 5'h01;
            REMOTE_TEMP_AVERAGING     <= `PIDC_AVG_RESET;
            LOOP_ENABLE               <= 1'b0;
        end else begin
            // Only 10 is active; 0x is power-down; factory 11 holds state
            if (power_state_r[1:0] != `PIDC_POWER_FACTORY)
                POWER_ACTIVE <= (power_state_r[1:0] == `PIDC_POWER_ACTIVE);
            CONVERSION_TRIGGER_SELECT <= general_config_zero_r[`PIDC_BIT_TRIGGER];
            if (new_filt <= `PIDC_FILT_MAX) begin
                FILTER_CODE     <= new_filt;
                FILTER_K        <= 5'h01 << new_filt;
                FILTER_FEEDBACK <= (5'h01 << new_filt) - 5'h01;
            end
            if (new_avg <= `PIDC_AVG_MAX)
                REMOTE_TEMP_AVERAGING <= new_avg;
            LOOP_ENABLE <= general_config_zero_r[`PIDC_BIT_LOOP];
        end
    end

    // ---------------------------------------------------------------------
    // Update interval lookup from applied codes
    // ---------------------------------------------------------------------
    always @* begin
        case (FILTER_CODE)
            3'h0:    cs_lim = sat22(CS_C0);
            3'h1:    cs_lim = sat22(CS_C1);
            3'h2:    cs_lim = sat22(CS_C2);
            3'h3:    cs_lim = sat22(CS_C3);
            default: cs_lim = sat22(CS_C4);
        endcase
        case (REMOTE_TEMP_AVERAGING)
            3'h0:    rt_lim = sat22(RT_C0);
            3'h1:    rt_lim = sat22(RT_C1);
            3'h2:    rt_lim = sat22(RT_C2);
            3'h3:    rt_lim = sat22(RT_C3);
            3'h4:    rt_lim = sat22(RT_C4);
            default: rt_lim = sat22(RT_C5);
        endcase
    end

    // ---------------------------------------------------------------------
    // Update tick timers, run only in active mode
    // ---------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cs_cnt_r  <= 22'h000000;
            rt_cnt_r  <= 22'h000000;
            CS_UPDATE <= 1'b0;
            RT_UPDATE <= 1'b0;
        end else begin
            CS_UPDATE <= 1'b0;
            RT_UPDATE <= 1'b0;
            if (!POWER_ACTIVE) begin
                cs_cnt_r <= 22'h000000;
                rt_cnt_r <= 22'h000000;
            end else begin
                if (cs_cnt_r + 22'h000001 >= cs_lim) begin
                    cs_cnt_r  <= 22'h000000;
                    CS_UPDATE <= 1'b1;
                end else
                    cs_cnt_r <= cs_cnt_r + 22'h000001;
                if (rt_cnt_r + 22'h000001 >= rt_lim) begin
                    rt_cnt_r  <= 22'h000000;
                    RT_UPDATE <= 1'b1;
                end else
                    rt_cnt_r <= rt_cnt_r + 22'h000001;
            end
        end
    end
endmodule

// file: tb/pidc_top_sva.sv
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
module pidc_top_sva #(
    parameter int TIME_SCALE = 1
) (
    input wire       SYS_CLK,
    input wire       RESET_N,
    input wire       CS_N,
    input wire       SDO_OE,
    input wire       POWER_ACTIVE,
    input wire       CONVERSION_TRIGGER_SELECT,
    input wire [2:0] FILTER_CODE,
    input wire [4:0] FILTER_K,
    input wire [4:0] FILTER_FEEDBACK,
    input wire [2:0] REMOTE_TEMP_AVERAGING,
    input wire       LOOP_ENABLE,
    input wire       CS_UPDATE,
    input wire       RT_UPDATE
);
    localparam int CS_US [5] = '{200, 3400, 6600, 13000, 25600};
    localparam int RT_US [6] = '{16000, 16000, 18000, 26000, 50000, 98000};
    int unsigned cs_gap_r;  // Cycles since the last current tick
    int unsigned rt_gap_r;  // Cycles since the last remote tick
    logic        cs_arm_r;  // Previous tick seen under the same code
    logic        rt_arm_r;  // Previous tick seen under the same code
    logic [2:0]  fc_r;      // Filter code one cycle back
    logic [2:0]  av_r;      // Averaging code one cycle back
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // Gap counters, armed only while power and code hold still
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_gap_r <= 0;
            rt_gap_r <= 0;
            cs_arm_r <= 1'b0;
            rt_arm_r <= 1'b0;
            fc_r     <= 3'h3;
            av_r     <= 3'h0;
        end else begin
            cs_gap_r <= CS_UPDATE ? 1 : cs_gap_r + 1;
            rt_gap_r <= RT_UPDATE ? 1 : rt_gap_r + 1;
            cs_arm_r <= POWER_ACTIVE && (FILTER_CODE == fc_r) && (CS_UPDATE || cs_arm_r);
            rt_arm_r <= POWER_ACTIVE && (REMOTE_TEMP_AVERAGING == av_r) && (RT_UPDATE || rt_arm_r);
            fc_r     <= FILTER_CODE;
            av_r     <= REMOTE_TEMP_AVERAGING;
        end
    end
    property p_k_pow; FILTER_K == (5'h01 << FILTER_CODE); endproperty
    a_k_pow: assert property (p_k_pow) else $error("filter constant off code");
    property p_feedback; FILTER_FEEDBACK == FILTER_K - 5'h01; endproperty
    a_feedback: assert property (p_feedback) else $error("feedback not K minus one");
    property p_filt_valid; FILTER_CODE <= 3'h4; endproperty
    a_filt_valid: assert property (p_filt_valid) else $error("invalid filter code in use");
    property p_avg_valid; REMOTE_TEMP_AVERAGING <= 3'h5; endproperty
    a_avg_valid: assert property (p_avg_valid) else $error("invalid averaging code in use");
    property p_cs_period; CS_UPDATE && cs_arm_r |-> cs_gap_r == CS_US[FILTER_CODE] * 20 / TIME_SCALE; endproperty
    a_cs_period: assert property (p_cs_period) else $error("current tick spacing wrong");
    property p_rt_period;
        RT_UPDATE && rt_arm_r |-> rt_gap_r == RT_US[REMOTE_TEMP_AVERAGING] * 20 / TIME_SCALE;
    endproperty
    a_rt_period: assert property (p_rt_period) else $error("remote tick spacing wrong");
    property p_down_quiet; !POWER_ACTIVE && !$past(POWER_ACTIVE) |-> !CS_UPDATE && !RT_UPDATE; endproperty
    a_down_quiet: assert property (p_down_quiet) else $error("tick while powered down");
    property p_oe_idle; CS_N [*6] |-> !SDO_OE; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven outside frame");
    property p_hold_in_frame;
        (!CS_N) [*8] |-> $stable(LOOP_ENABLE) && $stable(CONVERSION_TRIGGER_SELECT) && $stable(FILTER_CODE);
    endproperty
    a_hold_in_frame: assert property (p_hold_in_frame) else $error("setting moved inside frame");
    c_cs_tick: cover property (CS_UPDATE && cs_arm_r);
    c_rt_tick: cover property (RT_UPDATE && rt_arm_r);
    c_power_up: cover property ($rose(POWER_ACTIVE));
endmodule
bind pidc_top pidc_top_sva #(.TIME_SCALE(TIME_SCALE)) pidc_top_sva_i (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CS_N(CS_N), .SDO_OE(SDO_OE), .POWER_ACTIVE(POWER_ACTIVE),
    .CONVERSION_TRIGGER_SELECT(CONVERSION_TRIGGER_SELECT), .FILTER_CODE(FILTER_CODE), .FILTER_K(FILTER_K),
    .FILTER_FEEDBACK(FILTER_FEEDBACK), .REMOTE_TEMP_AVERAGING(REMOTE_TEMP_AVERAGING),
    .LOOP_ENABLE(LOOP_ENABLE), .CS_UPDATE(CS_UPDATE), .RT_UPDATE(RT_UPDATE));

// file: tb/pidc_host_model.sv
// Serial host model that frames register accesses
`timescale 1ns/100ps
module pidc_host_model (
    input  wire  SYS_CLK,
    output logic CS_N,
    output logic SCLK,
    output logic SDI,
    input  wire  SDO
);
    // Idle: no frame, clock stands low
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        SDI  = 1'b0;
    end
    // One frame; five clocks high and six low keep the sync stages happy
    task automatic xfer(input logic rw, input logic [6:0] adr, input logic [15:0] dat,
                        input int edges, output logic [15:0] rdat);
        logic [23:0] sh;
        int          i;
        sh = {rw, adr, dat};
        rdat = 16'h0000;
        @(posedge SYS_CLK);
        CS_N <= 1'b0;
        for (i = 0; i < edges; i++) begin
            @(posedge SYS_CLK);
            SDI <= sh[23 - (i % 24)];
            repeat (5) @(posedge SYS_CLK);
            SCLK <= 1'b1;
            if (i >= 8 && i < 24) rdat[23 - i] = SDO;
            repeat (5) @(posedge SYS_CLK);
            SCLK <= 1'b0;
        end
        repeat (5) @(posedge SYS_CLK);
        CS_N <= 1'b1;
        SDI  <= ~SDI; // Released line shows the inverse of the last bit
        repeat (12) @(posedge SYS_CLK); // Gap and commit time before the next frame
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb_top;
    localparam int          TS      = 1000;     // Shortens update intervals
    localparam logic [15:0] T_PART  = 16'h1357; // Arbitrary value
    localparam logic [15:0] T_REV   = 16'h0002; // Arbitrary value
    localparam logic [15:0] T_MAKER = 16'h2468; // Arbitrary value
    localparam int          CS_US [5] = '{200, 3400, 6600, 13000, 25600};
    localparam int          RT_US [6] = '{16000, 16000, 18000, 26000, 50000, 98000};
    localparam logic [1:0]  PV [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
    localparam logic        PE [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic        SYS_CLK = 1'b0;
    logic        RESET_N = 1'b0;
    wire         CS_N, SCLK, SDI, SDO, SDO_OE, POWER_ACTIVE, CONVERSION_TRIGGER_SELECT;
    wire         LOOP_ENABLE, CS_UPDATE, RT_UPDATE;
    wire [2:0]   FILTER_CODE, REMOTE_TEMP_AVERAGING;
    wire [4:0]   FILTER_K, FILTER_FEEDBACK;
    int          failures = 0;
    int          samples_checked = 0;
    int          oe_cycles = 0;     // Cycles with SDO driven
    always @(posedge SYS_CLK)
        if (SDO_OE === 1'b1) oe_cycles <= oe_cycles + 1;
    logic [15:0] rdat;
    always #25 SYS_CLK = ~SYS_CLK;
    pidc_top #(.PART_ID(T_PART), .REV_ID(T_REV), .MAKER_ID(T_MAKER), .TIME_SCALE(TS)) pidc_top_i (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO),
        .SDO_OE(SDO_OE), .POWER_ACTIVE(POWER_ACTIVE), .CONVERSION_TRIGGER_SELECT(CONVERSION_TRIGGER_SELECT),
        .FILTER_CODE(FILTER_CODE), .FILTER_K(FILTER_K), .FILTER_FEEDBACK(FILTER_FEEDBACK),
        .REMOTE_TEMP_AVERAGING(REMOTE_TEMP_AVERAGING), .LOOP_ENABLE(LOOP_ENABLE),
        .CS_UPDATE(CS_UPDATE), .RT_UPDATE(RT_UPDATE));
    // Released SDO shows the inverse of the last bit to the host
    pidc_host_model pidc_host_model_i (.SYS_CLK(SYS_CLK), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI),
        .SDO(SDO_OE ? SDO : ~SDO));
    // Verdict and end of run
    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Register words and counts
    task chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Decoded output levels
    task chk_sig(input string n, input logic [4:0] e, input logic [4:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d, input int n);
        pidc_host_model_i.xfer(1'b0, a, d, n, rdat);
    endtask
    task rd(input logic [6:0] a);
        pidc_host_model_i.xfer(1'b1, a, 16'h0000, 24, rdat);
    endtask
    task chk_dec(input logic t, input logic [2:0] c, input logic [2:0] a, input logic l);
        chk_sig("trigger", {4'h0, t}, {4'h0, CONVERSION_TRIGGER_SELECT});
        chk_sig("filter code", {2'h0, c}, {2'h0, FILTER_CODE});
        chk_sig("filter k", 5'h01 << c, FILTER_K);
        chk_sig("feedback", (5'h01 << c) - 5'h01, FILTER_FEEDBACK);
        chk_sig("averaging", {2'h0, a}, {2'h0, REMOTE_TEMP_AVERAGING});
        chk_sig("loop", {4'h0, l}, {4'h0, LOOP_ENABLE});
    endtask
    // Cycles between two ticks of one result, bounded
    task meas(input logic rt, output int n);
        int i;
        for (i = 0; i < 5000; i++) begin
            @(posedge SYS_CLK);
            #1;
            if ((rt ? RT_UPDATE : CS_UPDATE) === 1'b1) break;
        end
        for (n = 1; n < 5000; n++) begin
            @(posedge SYS_CLK);
            #1;
            if ((rt ? RT_UPDATE : CS_UPDATE) === 1'b1) break;
        end
        if (i == 5000 || n == 5000) begin
            failures++;
            $display("MISMATCH tick wait expected pulse seen none");
            end_of_test();
        end
    endtask
    task t_reset;
        rd(7'h02);
        chk_reg("power", 16'h0000, rdat);
        rd(7'h10);
        chk_reg("config", 16'h0300, rdat);
        chk_sig("power active", 5'h00, {4'h0, POWER_ACTIVE});
        chk_dec(1'b0, 3'h3, 3'h0, 1'b0);
    endtask
    task t_ids;
        int k;
        rd(7'h04);
        chk_reg("part id", T_PART, rdat);
        rd(7'h06);
        chk_reg("revision id", T_REV, rdat);
        k = oe_cycles;
        wr(7'h04, ~T_PART, 24);
        chk_reg("oe in write", 16'h0000, 16'(oe_cycles - k));
        wr(7'h0C, 16'hFFFF, 24);
        rd(7'h04);
        chk_reg("part id kept", T_PART, rdat);
        rd(7'h0C);
        chk_reg("maker id", T_MAKER, rdat);
        rd(7'h05);
        chk_reg("unmapped", 16'h0000, rdat);
    endtask
    // Active, factory code holds state, both down codes, back to active
    task t_power;
        int k;
        for (k = 0; k < 5; k++) begin
            wr(7'h02, {14'h2A5C, PV[k]}, 24);
            rd(7'h02);
            chk_reg("power", {14'h2A5C, PV[k]}, rdat);
            chk_sig("power active", {4'h0, PE[k]}, {4'h0, POWER_ACTIVE});
        end
    endtask
    // Frames of 23 and 25 edges leave everything as it was
    task t_short;
        wr(7'h10, 16'h0300, 24);
        wr(7'h10, 16'h1001, 23);
        wr(7'h10, 16'h1001, 25);
        rd(7'h10);
        chk_reg("config short", 16'h0300, rdat);
        chk_dec(1'b0, 3'h3, 3'h0, 1'b0);
    endtask
    // Every filter and averaging code, valid and not, with tick spacing
    task t_config;
        int          c;
        int          n;
        logic [2:0]  cc;
        logic [2:0]  f;
        logic [2:0]  a;
        logic [15:0] w;
        for (c = 0; c < 8; c++) begin
            cc = c[2:0];
            w = {3'h7, cc[0], 1'b1, cc, 1'b1, cc, 3'h4, cc[1]};
            f = (cc > 3'h4) ? 3'h4 : cc;
            a = (cc > 3'h5) ? 3'h5 : cc;
            wr(7'h10, w, 24);
            rd(7'h10);
            chk_reg("config", w, rdat);
            chk_dec(cc[0], f, a, cc[1]);
            meas(1'b0, n);
            chk_reg("cs interval", 16'(CS_US[f] * 20 / TS), 16'(n));
            meas(1'b1, n);
            chk_reg("rt interval", 16'(RT_US[a] * 20 / TS), 16'(n));
        end
    endtask
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        t_reset();
        t_ids();
        t_power();
        t_short();
        t_config();
        end_of_test();
    end
endmodule
